// *** logic/dss_consts.vh ***
`ifndef DSS_CONSTS_VH
`define DSS_CONSTS_VH
// System clock
`define DSS_CLK_MHZ          200
// Settling time in microseconds, least time, rounded up
`define DSS_SETTLE_US        100
`define DSS_SETTLE_CYC       (`DSS_SETTLE_US * `DSS_CLK_MHZ)
// Restore stage timeout to guard band, microseconds
`define DSS_GUARD_US         50
`define DSS_GUARD_CYC        (`DSS_GUARD_US * `DSS_CLK_MHZ)
// Step idle gap after which no more pulses are expected, microseconds
`define DSS_STEP_GAP_US      40
`define DSS_STEP_GAP_CYC     (`DSS_STEP_GAP_US * `DSS_CLK_MHZ)
// Velocity command codes
`define DSS_VEL_IDLE         8'h00
`define DSS_VEL_SLOW         8'h10
`define DSS_VEL_SEEK         8'h80
// Track counter width and maximum track
`define DSS_TRK_W            12
`define DSS_TRK_MAX          12'h3ff
// Head select field width
`define DSS_HS_W             4
`endif

// *** logic/dss_sync3.v ***
`timescale 1ns/10ps
// Three-stage synchroniser; output changes once stages two and three agree
module dss_sync3 (
  // Clock and reset
  input  wire clk_sys,
  input  wire rstn,
  // Data
  input  wire d,
  output reg  q
);
  reg s1;
  reg s2;
  reg s3;

  always @(posedge clk_sys) begin
    if (!rstn) begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
      q  <= 1'b1;
    end else begin
      s1 <= d;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3) begin
        q <= s3;
      end
    end
  end
endmodule

// *** logic/dss_seq.v ***
`timescale 1ns/10ps
`include "dss_consts.vh"

module dss_seq (
  // Clock and reset (single crystal-derived clock)
  input  wire                   clk_sys,
  input  wire                   rstn,
  input  wire                   por_active,
  // Controller strobes, active low
  input  wire                   unit_select_n,
  input  wire                   step_n,
  input  wire                   direction_n,
  input  wire                   write_gate_n,
  input  wire [`DSS_HS_W-1:0]   head_sel_n,
  // Servo inputs
  input  wire                   off_track,
  input  wire                   on_peak,
  input  wire                   track_zero_det,
  input  wire                   guard_band,
  // Servo controls
  output reg                    servo_enable,
  output reg                    seek_mode,
  output reg                    odd_polarity,
  output reg                    dir_out,
  output reg  [7:0]             velocity_cmd,
  output reg                    coil_drive_a,
  output reg                    coil_drive_b,
  output reg                    write_enable,
  // Head decode
  output reg  [1:0]             chip_enable_n,
  output reg  [1:0]             head_bits,
  // Open-collector status: out is level, oe low drives
  output reg                    seek_done_n_out,
  output reg                    seek_done_n_oe_n,
  output reg                    ready_n_out,
  output reg                    ready_n_oe_n,
  output reg                    write_fault_n_out,
  output reg                    write_fault_n_oe_n,
  output reg                    track_zero_n_out,
  output reg                    track_zero_n_oe_n,
  // Internal status
  output reg                    drive_ready_internal,
  output reg  [`DSS_TRK_W-1:0]  track_pos
);

  localparam [6:0] ST_RESET  = 7'h01;
  localparam [6:0] ST_GUARD  = 7'h02;
  localparam [6:0] ST_SETTLE = 7'h04;
  localparam [6:0] ST_SLOW   = 7'h08;
  localparam [6:0] ST_IDLE   = 7'h10;
  localparam [6:0] ST_SEEK   = 7'h20;
  localparam [6:0] ST_FOLLOW = 7'h40;

  wire sel_q;
  wire step_q;
  wire dir_q;
  wire wg_q;
  wire por_q;
  wire peak_q;
  wire offt_q;
  wire tz_q;
  wire gb_q;
  wire [`DSS_HS_W-1:0] hs_q;
  genvar gi;

  // Pin inputs all pass the three-stage filter
  dss_sync3 u_sel (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .d       (unit_select_n),
    .q       (sel_q));
  dss_sync3 u_step (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .d       (step_n),
    .q       (step_q));
  dss_sync3 u_dir (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .d       (direction_n),
    .q       (dir_q));
  dss_sync3 u_wg (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .d       (write_gate_n),
    .q       (wg_q));
  dss_sync3 u_por (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .d       (~por_active),
    .q       (por_q));
  dss_sync3 u_peak (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .d       (~on_peak),
    .q       (peak_q));
  dss_sync3 u_offt (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .d       (~off_track),
    .q       (offt_q));
  dss_sync3 u_tz (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .d       (~track_zero_det),
    .q       (tz_q));
  dss_sync3 u_gb (
    .clk_sys (clk_sys),
    .rstn    (rstn),
    .d       (~guard_band),
    .q       (gb_q));

  // Head select pins are filtered like the strobes
  generate
    for (gi = 0; gi < `DSS_HS_W; gi = gi + 1) begin : g_hs
      dss_sync3 u_hs (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .d       (head_sel_n[gi]),
        .q       (hs_q[gi]));
    end
  endgenerate

  wire selected   = ~sel_q;
  wire wg_active  = ~wg_q & selected;
  wire por_on     = ~por_q;
  wire peak_on    = ~peak_q;
  wire offt_on    = ~offt_q;
  wire tz_on      = ~tz_q;
  wire gb_on      = ~gb_q;

  reg        step_prev;
  reg        peak_prev;
  wire       step_edge = step_prev & ~step_q & selected;
  wire       peak_edge = ~peak_prev & peak_on;

  reg  [6:0]            state;
  reg                   seek_done;
  reg                   ready;
  reg                   wfault;
  reg  [`DSS_TRK_W-1:0] pend_steps;
  reg  [`DSS_TRK_W-1:0] trk_min;
  reg  [`DSS_TRK_W-1:0] trk_max;
  reg  [19:0]           timer;
  reg  [19:0]           step_gap;

  // Decode of head select lines, used twice
  function [3:0] hs_decode;
    input [`DSS_HS_W-1:0] hs_n;
    reg   [`DSS_HS_W-1:0] h;
    begin
      h = ~hs_n;
      hs_decode = {(h[2] ? 1'b0 : 1'b1), (h[2] ? 1'b1 : 1'b0), h[1], h[0]};
    end
  endfunction

  wire [3:0] hs_dec = hs_decode(hs_q);

  // A step that drops seek done with write gate active trips the fault
  wire done_fall = seek_done & step_edge;

  always @(posedge clk_sys) begin
    if (!rstn || por_on) begin
      state        <= ST_RESET;
      step_prev    <= 1'b1;
      peak_prev    <= 1'b0;
      seek_done    <= 1'b0;
      ready        <= 1'b0;
      wfault       <= 1'b0;
      servo_enable <= 1'b0;
      seek_mode    <= 1'b0;
      odd_polarity <= 1'b0;
      dir_out      <= 1'b0;
      velocity_cmd <= `DSS_VEL_IDLE;
      write_enable <= 1'b0;
      pend_steps   <= {`DSS_TRK_W{1'b0}};
      track_pos    <= {`DSS_TRK_W{1'b0}};
      trk_min      <= {`DSS_TRK_W{1'b0}};
      trk_max      <= {`DSS_TRK_W{1'b0}};
      timer        <= 20'h00000;
      step_gap     <= 20'h00000;
    end else begin
      step_prev <= step_q;
      peak_prev <= peak_on;
      if (step_edge) begin
        seek_done <= 1'b0;
      end
      if (done_fall && wg_active) begin
        wfault <= 1'b1;
      end
      // Fault latches until reset; write path is cut while faulted
      write_enable <= wg_active & ~wfault & ~(done_fall & wg_active) & seek_done;
      step_gap <= step_edge ? 20'h00000 : (step_gap == 20'hfffff ? step_gap : step_gap + 20'h00001);
      case (state)
        ST_RESET: begin
          servo_enable <= 1'b1;
          seek_mode    <= 1'b1;
          odd_polarity <= 1'b0;
          dir_out      <= 1'b1;
          velocity_cmd <= `DSS_VEL_SEEK;
          timer        <= 20'h00000;
          state        <= ST_GUARD;
        end
        ST_GUARD: begin
          timer <= timer + 20'h00001;
          if (gb_on || timer == `DSS_GUARD_CYC) begin
            seek_mode    <= 1'b0;
            odd_polarity <= 1'b1;
            velocity_cmd <= `DSS_VEL_IDLE;
            timer        <= 20'h00000;
            state        <= ST_SETTLE;
          end
        end
        ST_SETTLE: begin
          timer <= offt_on ? 20'h00000 : timer + 20'h00001;
          if (!offt_on && timer == `DSS_SETTLE_CYC - 1) begin
            seek_mode    <= 1'b1;
            odd_polarity <= 1'b0;
            dir_out      <= 1'b1;
            velocity_cmd <= `DSS_VEL_SLOW;
            state        <= ST_SLOW;
          end
        end
        ST_SLOW: begin
          if (tz_on) begin
            seek_mode    <= 1'b0;
            odd_polarity <= 1'b1;
            velocity_cmd <= `DSS_VEL_IDLE;
            track_pos    <= {`DSS_TRK_W{1'b0}};
            trk_min      <= {`DSS_TRK_W{1'b0}};
            trk_max      <= `DSS_TRK_MAX;
            timer        <= 20'h00000;
            state        <= ST_FOLLOW;
          end
        end
        ST_IDLE: begin
          timer <= offt_on ? 20'h00000 : timer;
          if (offt_on) begin
            seek_done <= 1'b0;
            state     <= ST_FOLLOW;
          end else if (step_edge && !wg_active && ready && seek_done) begin
            dir_out      <= dir_q;
            seek_mode    <= 1'b1;
            odd_polarity <= 1'b0;
            velocity_cmd <= `DSS_VEL_SEEK;
            pend_steps   <= {{(`DSS_TRK_W-1){1'b0}}, 1'b1};
            state        <= ST_SEEK;
          end
        end
        ST_SEEK: begin
          // Step and crossing in same cycle cancel out
          if (step_edge && !peak_edge) begin
            pend_steps <= pend_steps + {{(`DSS_TRK_W-1){1'b0}}, 1'b1};
          end else if (peak_edge && !step_edge && pend_steps != {`DSS_TRK_W{1'b0}}) begin
            pend_steps <= pend_steps - {{(`DSS_TRK_W-1){1'b0}}, 1'b1};
          end
          if (peak_edge) begin
            track_pos <= dir_out ? (track_pos == trk_min ? track_pos : track_pos - {{(`DSS_TRK_W-1){1'b0}}, 1'b1})
                                 : (track_pos == trk_max ? track_pos : track_pos + {{(`DSS_TRK_W-1){1'b0}}, 1'b1});
          end
          // Nothing pending after the gap also ends the seek, else an early last crossing hangs it
          if (!step_edge && step_gap >= `DSS_STEP_GAP_CYC
              && (pend_steps == {`DSS_TRK_W{1'b0}}
                  || (peak_edge && pend_steps == {{(`DSS_TRK_W-1){1'b0}}, 1'b1}))) begin
            seek_mode    <= 1'b0;
            odd_polarity <= 1'b1;
            velocity_cmd <= `DSS_VEL_IDLE;
            timer        <= 20'h00000;
            state        <= ST_FOLLOW;
          end
        end
        ST_FOLLOW: begin
          timer <= offt_on ? 20'h00000 : timer + 20'h00001;
          if (step_edge && ready) begin
            timer <= 20'h00000;
          end else if (!offt_on && timer == `DSS_SETTLE_CYC - 1) begin
            seek_done <= 1'b1;
            ready     <= 1'b1;
            state     <= ST_IDLE;
          end
        end
        default: state <= ST_RESET;
      endcase
    end
  end

  // Coil output, enabled only with servo enable
  always @(posedge clk_sys) begin
    if (!rstn || por_on) begin
      coil_drive_a         <= 1'b0;
      coil_drive_b         <= 1'b0;
      drive_ready_internal <= 1'b0;
    end else begin
      coil_drive_a <= servo_enable & ~odd_polarity;
      coil_drive_b <= servo_enable & odd_polarity;
      drive_ready_internal <= ready;
    end
  end

  // Head decode and open-collector status
  always @(posedge clk_sys) begin
    if (!rstn) begin
      chip_enable_n      <= 2'h3;
      head_bits          <= 2'h0;
      seek_done_n_out    <= 1'b1;
      seek_done_n_oe_n   <= 1'b1;
      ready_n_out        <= 1'b1;
      ready_n_oe_n       <= 1'b1;
      write_fault_n_out  <= 1'b1;
      write_fault_n_oe_n <= 1'b1;
      track_zero_n_out   <= 1'b1;
      track_zero_n_oe_n  <= 1'b1;
    end else begin
      chip_enable_n <= selected ? {~hs_dec[2], ~hs_dec[3]} : 2'h3;
      head_bits     <= hs_dec[1:0];
      // Drive low only for a true status of a selected unit
      seek_done_n_out    <= 1'b0;
      ready_n_out        <= 1'b0;
      write_fault_n_out  <= 1'b0;
      track_zero_n_out   <= 1'b0;
      seek_done_n_oe_n   <= ~(selected & seek_done & ~por_on);
      ready_n_oe_n       <= ~(selected & ready & ~por_on);
      write_fault_n_oe_n <= ~(selected & wfault & ~por_on);
      track_zero_n_oe_n  <= ~(selected & tz_on & ~por_on);
    end
  end

endmodule

// *** sim/dss_seq_props.sv ***
`timescale 1ns/10ps
`include "dss_consts.vh"
module dss_seq_props (
  // Clock and resets
  input wire clk_sys,
  input wire rstn,
  input wire por_active,
  // Inputs watched
  input wire unit_select_n,
  input wire step_n,
  input wire off_track,
  // Outputs watched
  input wire servo_enable,
  input wire seek_mode,
  input wire coil_drive_a,
  input wire coil_drive_b,
  input wire write_enable,
  input wire seek_done_n_out,
  input wire seek_done_n_oe_n,
  input wire ready_n_out,
  input wire ready_n_oe_n,
  input wire write_fault_n_oe_n,
  input wire drive_ready_internal
);
  // Raw clean time; the filtered copy inside is no longer, save when the filter swallows a one-cycle glitch
  reg [15:0] clean;
  always @(posedge clk_sys) begin
    if (!rstn || off_track) clean <= 16'h0000;
    else if (clean != 16'hffff) clean <= clean + 16'h0001;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence s_in_seek; seek_mode [*3]; endsequence
  sequence s_unsel; unit_select_n [*8]; endsequence
  sequence s_por; por_active [*8]; endsequence
  property p_coil; !servo_enable && !$past(servo_enable) |-> !coil_drive_a && !coil_drive_b; endproperty
  a_coil: assert property (p_coil) else $error("coil driven with servo off");
  property p_unsel; s_unsel |-> seek_done_n_oe_n && ready_n_oe_n && write_fault_n_oe_n; endproperty
  a_unsel: assert property (p_unsel) else $error("status driven while unselected");
  property p_low; $past(rstn) |-> seek_done_n_out == 1'b0 && ready_n_out == 1'b0; endproperty
  a_low: assert property (p_low) else $error("status level not low");
  property p_ready; !drive_ready_internal && !$past(drive_ready_internal) |-> ready_n_oe_n; endproperty
  a_ready: assert property (p_ready) else $error("ready shown before restore");
  property p_seek_servo; seek_mode |-> servo_enable; endproperty
  a_seek_servo: assert property (p_seek_servo) else $error("seek mode without servo");
  property p_in_seek; s_in_seek |-> seek_done_n_oe_n; endproperty
  a_in_seek: assert property (p_in_seek) else $error("seek done during seek");
  property p_step; $fell(step_n) |-> ##[1:12] seek_done_n_oe_n; endproperty
  a_step: assert property (p_step) else $error("step did not drop seek done");
  property p_fault; !write_fault_n_oe_n && !$past(write_fault_n_oe_n) |-> !write_enable; endproperty
  a_fault: assert property (p_fault) else $error("write left on under fault");
  property p_por; s_por |-> !servo_enable && ready_n_oe_n && seek_done_n_oe_n; endproperty
  a_por: assert property (p_por) else $error("running under power-on reset");
  property p_settle; $fell(seek_done_n_oe_n) && !$past(unit_select_n, 8) |-> clean >= `DSS_SETTLE_CYC; endproperty
  a_settle: assert property (p_settle) else $error("seek done before settle time");
endmodule
bind dss_seq dss_seq_props dss_seq_props_inst (.clk_sys, .rstn, .por_active, .unit_select_n, .step_n, .off_track,
  .servo_enable, .seek_mode, .coil_drive_a, .coil_drive_b, .write_enable, .seek_done_n_out, .seek_done_n_oe_n,
  .ready_n_out, .ready_n_oe_n, .write_fault_n_oe_n, .drive_ready_internal);

// *** sim/dss_ctrl_model.sv ***
`timescale 1ns/10ps
module dss_ctrl_model (
  // Clock
  input  wire       clk_sys,
  // Commands from bench
  input  wire       go,
  input  wire       bypass,
  input  wire [3:0] n_steps,
  // Status lines from drive
  input  wire       seek_done_n_out,
  input  wire       seek_done_n_oe_n,
  input  wire       ready_n_out,
  input  wire       ready_n_oe_n,
  // Step strobe to drive, busy flag to bench
  output reg        step_n,
  output reg        busy
);
  // Pulled-up open-collector lines
  wire sd_line  = seek_done_n_oe_n ? 1'b1 : seek_done_n_out;
  wire rdy_line = ready_n_oe_n ? 1'b1 : ready_n_out;
  initial begin
    step_n = 1'b1;
    busy = 1'b0;
    forever begin
      @(posedge clk_sys);
      if (go) begin
        #1 busy = 1'b1;
        // Bypass sends steps a real controller would hold back
        while (!bypass && (sd_line !== 1'b0 || rdy_line !== 1'b0)) @(posedge clk_sys);
        repeat (n_steps) begin
          @(posedge clk_sys);
          #1 step_n = 1'b0;
          repeat (20) @(posedge clk_sys);
          #1 step_n = 1'b1;
          repeat (380) @(posedge clk_sys);
        end
        #1 busy = 1'b0;
      end
    end
  end
endmodule

// *** sim/test_disk_seek_servo_sequencer.sv ***
`timescale 1ns/10ps
`include "dss_consts.vh"
module test_disk_seek_servo_sequencer;
  reg        clk_sys = 1'b0, rstn = 1'b0, por_active = 1'b0, unit_select_n = 1'b0, direction_n = 1'b1;
  reg        write_gate_n = 1'b1, off_track = 1'b0, on_peak = 1'b0, track_zero_det = 1'b0, guard_band = 1'b0;
  reg        go = 1'b0, bypass = 1'b0;
  reg  [3:0] n_steps = 4'h0;
  wire       step_n, busy, servo_enable, seek_mode, dir_out, write_enable, drive_ready_internal;
  wire       odd_polarity, coil_drive_a, coil_drive_b, track_zero_n_out, track_zero_n_oe_n;
  wire [1:0] chip_enable_n, head_bits;
  reg  [3:0] head_sel_n = 4'hf;
  wire       seek_done_n_out, seek_done_n_oe_n, ready_n_out, ready_n_oe_n, write_fault_n_out, write_fault_n_oe_n;
  wire [7:0] velocity_cmd;
  wire [`DSS_TRK_W-1:0] track_pos;
  integer    n_errors = 0, checks_done = 0, i;

  dss_seq dss_seq_inst (.clk_sys, .rstn, .por_active, .unit_select_n, .step_n, .direction_n, .write_gate_n,
    .head_sel_n, .off_track, .on_peak, .track_zero_det, .guard_band, .servo_enable, .seek_mode,
    .odd_polarity, .dir_out, .velocity_cmd, .coil_drive_a, .coil_drive_b, .write_enable,
    .chip_enable_n, .head_bits, .seek_done_n_out, .seek_done_n_oe_n, .ready_n_out, .ready_n_oe_n,
    .write_fault_n_out, .write_fault_n_oe_n, .track_zero_n_out, .track_zero_n_oe_n,
    .drive_ready_internal, .track_pos);
  dss_ctrl_model dss_ctrl_model_inst (.clk_sys, .go, .bypass, .n_steps, .seek_done_n_out, .seek_done_n_oe_n,
    .ready_n_out, .ready_n_oe_n, .step_n, .busy);

  task chk_bit(input reg e, input reg a);
    checks_done = checks_done + 1;
    if (a !== e) begin
      n_errors = n_errors + 1;
      $display("MISMATCH %0t exp=%h act=%h", $time, e, a);
    end
  endtask
  task chk_trk(input reg [`DSS_TRK_W-1:0] e, input reg [`DSS_TRK_W-1:0] a);
    checks_done = checks_done + 1;
    if (a !== e) begin
      n_errors = n_errors + 1;
      $display("MISMATCH %0t exp=%h act=%h", $time, e, a);
    end
  endtask
  task chk_pair(input reg [1:0] e, input reg [1:0] a);
    checks_done = checks_done + 1;
    if (a !== e) begin
      n_errors = n_errors + 1;
      $display("MISMATCH %0t exp=%h act=%h", $time, e, a);
    end
  endtask
  task tick(input integer n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task pulse_peak(input integer n);
    repeat (n) begin
      on_peak = 1'b1;
      tick(10);
      on_peak = 1'b0;
      tick(40);
    end
  endtask
  task step(input reg [3:0] n, input reg byp);
    bypass = byp;
    n_steps = n;
    go = 1'b1;
    tick(1);
    go = 1'b0;
    tick(2);
    for (i = 0; i < 8000 && busy === 1'b1; i = i + 1) tick(1);
    chk_bit(1'b0, busy);
  endtask
  task test_done;
    $display("mismatches %0d, checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task t_restore;
    chk_bit(1'b1, ready_n_oe_n);
    chk_bit(1'b0, servo_enable);
    rstn = 1'b1;
    guard_band = 1'b1;
    for (i = 0; i < 45000 && velocity_cmd !== `DSS_VEL_SLOW; i = i + 1) tick(1);
    chk_bit(1'b1, velocity_cmd === `DSS_VEL_SLOW);
    chk_bit(1'b1, dir_out);
    chk_bit(1'b1, seek_done_n_oe_n);
    guard_band = 1'b0;
    pulse_peak(2);
    track_zero_det = 1'b1;
    for (i = 0; i < 30000 && ready_n_oe_n !== 1'b0; i = i + 1) tick(1);
    chk_bit(1'b0, ready_n_oe_n);
    chk_bit(1'b0, seek_done_n_oe_n);
    chk_trk(12'h000, track_pos);
    chk_bit(1'b1, odd_polarity);
    chk_bit(1'b1, coil_drive_b);
    chk_bit(1'b0, coil_drive_a);
    chk_bit(1'b0, track_zero_n_oe_n);
  endtask
  task t_deselect;
    head_sel_n = 4'hb;
    tick(12);
    chk_pair(2'b01, chip_enable_n);
    chk_pair(2'b00, head_bits);
    unit_select_n = 1'b1;
    write_gate_n = 1'b0;
    tick(12);
    chk_bit(1'b1, ready_n_oe_n);
    chk_pair(2'b11, chip_enable_n);
    chk_bit(1'b0, write_enable);
    step(4'h1, 1'b1);
    chk_bit(1'b0, seek_mode);
    write_gate_n = 1'b1;
    tick(12);
    head_sel_n = 4'hc;
    unit_select_n = 1'b0;
    tick(12);
    chk_bit(1'b0, seek_done_n_oe_n);
    chk_pair(2'b10, chip_enable_n);
    chk_pair(2'b11, head_bits);
  endtask
  task t_seek;
    direction_n = 1'b0;
    track_zero_det = 1'b0;
    step(4'h3, 1'b0);
    chk_bit(1'b1, seek_mode);
    chk_bit(1'b0, dir_out);
    chk_bit(1'b0, odd_polarity);
    chk_bit(1'b1, coil_drive_a);
    chk_bit(1'b1, track_zero_n_oe_n);
    pulse_peak(2);
    tick(`DSS_STEP_GAP_CYC + 200);
    chk_bit(1'b1, seek_mode);
    pulse_peak(1);
    for (i = 0; i < 200 && seek_mode !== 1'b0; i = i + 1) tick(1);
    chk_bit(1'b0, seek_mode);
    chk_trk(12'h003, track_pos);
    chk_bit(1'b1, odd_polarity);
    tick(1000);
    off_track = 1'b1;
    tick(20);
    off_track = 1'b0;
    for (i = 0; i < 30000 && seek_done_n_oe_n !== 1'b0; i = i + 1) tick(1);
    chk_bit(1'b1, i >= `DSS_SETTLE_CYC && i <= `DSS_SETTLE_CYC + 10);
  endtask
  task t_fault;
    write_gate_n = 1'b0;
    tick(12);
    chk_bit(1'b1, write_enable);
    step(4'h1, 1'b1);
    chk_bit(1'b0, write_fault_n_oe_n);
    chk_bit(1'b0, seek_mode);
    chk_bit(1'b0, write_fault_n_out);
    chk_bit(1'b0, track_zero_n_out);
    por_active = 1'b1;
    tick(12);
    chk_bit(1'b1, write_fault_n_oe_n);
    chk_bit(1'b0, coil_drive_a);
    chk_bit(1'b0, coil_drive_b);
    por_active = 1'b0;
    tick(12);
    chk_bit(1'b1, servo_enable);
    chk_bit(1'b1, coil_drive_a);
    chk_bit(1'b1, ready_n_oe_n);
    chk_bit(1'b1, seek_done_n_oe_n);
  endtask

  initial forever #2.5 clk_sys = ~clk_sys;
  initial begin
    tick(6);
    t_restore;
    t_deselect;
    t_seek;
    t_fault;
    test_done;
  end
  initial begin
    repeat (95000) @(posedge clk_sys);
    n_errors = n_errors + 1;
    test_done;
  end
endmodule
